// ### rtl/dph_prefetch_handler.sv
// Data prefetch handler: executes the prefetch instruction between pipeline and caches.
// Assumes pipeline, translation and cache ports all run on i_ref_clk.
//
// Behaviour
// RQ1: Decode major 011000, minor 0010, zero bits
// RQ2: Address is base plus sign-extended offset
// RQ3: Five-bit hint chooses the prefetch action
// RQ4: Any action allowed if state stays unchanged
// RQ5: Only store preallocate may alter visible state
// RQ6: Addressing faults dropped silently, no data moved
// RQ7: Invisible actions like writeback still allowed
// RQ8: Reporting bus or cache errors is optional
// RQ9: Uncached addresses: no memory operation at all
// RQ10: Memory operation uses address's own attributes
// RQ11: Cached address fetches block containing address
// RQ12: Coherent attribute issues coherent memory transaction
// RQ13: Prefetch obeys memory barrier ordering rules
// RQ14: Hint 0 fetches as for a load
// RQ15: Hint 1 fetches as for a store
// RQ16: Hints 4-7 streamed and retained placement
// RQ17: Hints 8-15 level two, 16-23 level three
// RQ18: Hint 24 raises reserved instruction exception
// RQ19: Other unhandled hints retire as no-op
`timescale 1ns/1ps
`default_nettype none
`include "dph_params.svh"

module dph_prefetch_handler #(
  parameter int LINE_BYTES = `DPH_LINE_BYTES_DEFAULT,
  parameter bit REPORT_BUS_ERR = 1'b0,
  parameter bit ENABLE_PREALLOC = 1'b0,
  parameter logic [4:0] PREALLOC_HINT = `DPH_HINT_PREALLOC_DEFAULT
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_instr_valid,
  input wire logic [31:0] i_instr,
  input wire logic [31:0] i_base_value,
  output logic o_ready,
  output logic o_busy,
  output logic o_retire,
  output logic o_ri_exc,
  output logic o_bus_err_exc,
  output logic o_xlat_req,
  output logic [31:0] o_xlat_vaddr,
  input wire logic i_xlat_ack,
  input wire logic i_xlat_fault,
  input wire logic i_xlat_uncached,
  input wire logic i_xlat_coherent,
  input wire logic [2:0] i_xlat_cache_attr,
  input wire logic [31:0] i_xlat_paddr,
  input wire logic i_sync_pending,
  output logic o_mem_req,
  output logic [31:0] o_mem_addr,
  output dph_pkg::dph_action_e o_mem_kind,
  output logic [1:0] o_mem_level,
  output logic o_mem_stream,
  output logic o_mem_retain,
  output logic o_mem_coherent,
  output logic [2:0] o_mem_cache_attr,
  input wire logic i_mem_ready,
  input wire logic i_mem_done,
  input wire logic i_mem_err
);
  import dph_pkg::*;

  localparam int LINE_SHIFT = $clog2(LINE_BYTES);
  localparam logic [31:0] LINE_MASK = ~((32'h1 << LINE_SHIFT) - 32'h1);

  typedef enum logic [2:0] {
    DPH_ST_IDLE,
    DPH_ST_XLAT,
    DPH_ST_ORDER,
    DPH_ST_ISSUE,
    DPH_ST_WAIT
  } dph_state_e;

  typedef struct packed {
    dph_state_e state;
    dph_action_s action;
    logic ready;
    logic busy;
    logic retire;
    logic ri_exc;
    logic bus_err;
    logic xlat_req;
    logic [31:0] xlat_vaddr;
    logic mem_req;
    logic [31:0] mem_addr;
    dph_action_e mem_kind;
    logic [1:0] mem_level;
    logic mem_stream;
    logic mem_retain;
    logic mem_coherent;
    logic [2:0] mem_cache_attr;
  } dph_regs_s;

  localparam dph_regs_s RESET_VALUE = '{
    state: DPH_ST_IDLE,
    action: '{kind: DPH_ACT_NOP, level: `DPH_LEVEL_L1, stream: 1'b0, retain: 1'b0},
    ready: 1'b1,
    busy: 1'b0,
    retire: 1'b0,
    ri_exc: 1'b0,
    bus_err: 1'b0,
    xlat_req: 1'b0,
    xlat_vaddr: `DPH_RST_ADDR,
    mem_req: 1'b0,
    mem_addr: `DPH_RST_ADDR,
    mem_kind: DPH_ACT_NOP,
    mem_level: `DPH_LEVEL_L1,
    mem_stream: 1'b0,
    mem_retain: 1'b0,
    mem_coherent: 1'b0,
    mem_cache_attr: `DPH_RST_CACHE_ATTR
  };

  dph_regs_s r;
  dph_regs_s next_r;
  logic dec_is_prefetch;
  dph_action_s dec_action;
  logic [31:0] dec_eff_addr;

  dph_decode #(
    .PREALLOC_HINT(PREALLOC_HINT),
    .ENABLE_PREALLOC(ENABLE_PREALLOC)
  ) u_decode (
    .i_instr(i_instr),
    .i_base_value(i_base_value),
    .o_is_prefetch(dec_is_prefetch),
    .o_action(dec_action),
    .o_eff_addr(dec_eff_addr)
  );

  always_comb begin
    next_r = r;
    next_r.retire = 1'b0;
    next_r.ri_exc = 1'b0;
    next_r.bus_err = 1'b0;
    case (r.state)
      DPH_ST_IDLE: begin
        if (i_instr_valid && dec_is_prefetch) begin // [RQ1]
          next_r.action = dec_action;
          next_r.xlat_vaddr = dec_eff_addr; // [RQ2]
          case (dec_action.kind)
            DPH_ACT_RESERVED: begin
              next_r.retire = 1'b1;
              next_r.ri_exc = 1'b1; // [RQ18]
            end
            DPH_ACT_NOP: next_r.retire = 1'b1; // [RQ19] [RQ4]
            default: begin
              next_r.state = DPH_ST_XLAT;
              next_r.ready = 1'b0;
              next_r.busy = 1'b1;
              next_r.xlat_req = 1'b1;
            end
          endcase
        end
      end
      DPH_ST_XLAT: begin
        if (i_xlat_ack) begin
          next_r.xlat_req = 1'b0;
          if (i_xlat_fault || i_xlat_uncached) begin
            // Faulting or uncached: retire quietly, touch no line
            next_r.state = DPH_ST_IDLE; // [RQ6] [RQ9]
            next_r.ready = 1'b1;
            next_r.busy = 1'b0;
            next_r.retire = 1'b1;
          end else begin
            next_r.state = DPH_ST_ORDER;
            next_r.mem_addr = i_xlat_paddr & LINE_MASK; // [RQ11]
            next_r.mem_kind = r.action.kind; // [RQ14] [RQ15] [RQ5] [RQ7]
            next_r.mem_level = r.action.level; // [RQ17]
            next_r.mem_stream = r.action.stream; // [RQ16]
            next_r.mem_retain = r.action.retain; // [RQ16]
            next_r.mem_coherent = i_xlat_coherent; // [RQ12]
            next_r.mem_cache_attr = i_xlat_cache_attr; // [RQ10]
          end
        end
      end
      DPH_ST_ORDER: begin
        // Older barrier work must drain before this prefetch reaches memory
        if (!i_sync_pending) begin // [RQ13]
          next_r.state = DPH_ST_ISSUE;
          next_r.mem_req = 1'b1;
        end
      end
      DPH_ST_ISSUE: begin
        if (i_mem_ready) begin
          next_r.state = DPH_ST_WAIT;
          next_r.mem_req = 1'b0;
        end
      end
      DPH_ST_WAIT: begin
        // Busy holds until completion so a later barrier sees this transfer
        if (i_mem_done) begin // [RQ13]
          next_r.state = DPH_ST_IDLE;
          next_r.ready = 1'b1;
          next_r.busy = 1'b0;
          next_r.retire = 1'b1;
          next_r.bus_err = REPORT_BUS_ERR && i_mem_err; // [RQ8]
        end
      end
      default: next_r = RESET_VALUE;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r <= RESET_VALUE;
    end else begin
      r <= next_r;
    end
  end

  assign o_ready = r.ready;
  assign o_busy = r.busy;
  assign o_retire = r.retire;
  assign o_ri_exc = r.ri_exc;
  assign o_bus_err_exc = r.bus_err;
  assign o_xlat_req = r.xlat_req;
  assign o_xlat_vaddr = r.xlat_vaddr;
  assign o_mem_req = r.mem_req;
  assign o_mem_addr = r.mem_addr;
  assign o_mem_kind = r.mem_kind;
  assign o_mem_level = r.mem_level;
  assign o_mem_stream = r.mem_stream;
  assign o_mem_retain = r.mem_retain;
  assign o_mem_coherent = r.mem_coherent;
  assign o_mem_cache_attr = r.mem_cache_attr;

endmodule : dph_prefetch_handler
`default_nettype wire

// ### rtl/dph_params.svh
// Constants of the data prefetch handler: encodings, hint codes, reset values.
// Included by the package and the design modules; definitions only.
`ifndef DPH_PARAMS_SVH
`define DPH_PARAMS_SVH

`define DPH_MAJOR_OPCODE 6'h18
`define DPH_MINOR_CODE 4'h2
`define DPH_ZERO_FIELD 3'h0
`define DPH_MAJOR_MSB 31
`define DPH_MAJOR_LSB 26
`define DPH_HINT_MSB 25
`define DPH_HINT_LSB 21
`define DPH_BASE_MSB 20
`define DPH_BASE_LSB 16
`define DPH_MINOR_MSB 15
`define DPH_MINOR_LSB 12
`define DPH_ZERO_MSB 11
`define DPH_ZERO_LSB 9
`define DPH_OFFSET_MSB 8
`define DPH_OFFSET_LSB 0
`define DPH_OFFSET_WIDTH 9

`define DPH_HINT_LOAD 3'h0
`define DPH_HINT_STORE 3'h1
`define DPH_HINT_LRU 3'h2
`define DPH_HINT_IMPL 3'h3
`define DPH_HINT_LOAD_STREAMED 3'h4
`define DPH_HINT_STORE_STREAMED 3'h5
`define DPH_HINT_LOAD_RETAINED 3'h6
`define DPH_HINT_STORE_RETAINED 3'h7
`define DPH_HINT_LEVELED_LIMIT 5'h18
`define DPH_HINT_RESERVED 5'h18
`define DPH_HINT_PREALLOC_DEFAULT 5'h1f

`define DPH_LEVEL_L1 2'h0
`define DPH_LEVEL_L2 2'h1
`define DPH_LEVEL_L3 2'h2

`define DPH_RST_ADDR 32'h0000_0000
`define DPH_RST_CACHE_ATTR 3'h0
`define DPH_LINE_BYTES_DEFAULT 32

`endif

// ### rtl/dph_pkg.sv
// Types shared by the data prefetch handler modules.
// Assumes dph_params.svh is on the include path.
`include "dph_params.svh"

package dph_pkg;

  typedef enum logic [2:0] {
    DPH_ACT_NOP,
    DPH_ACT_LOAD,
    DPH_ACT_STORE,
    DPH_ACT_LRU,
    DPH_ACT_PREALLOC,
    DPH_ACT_RESERVED
  } dph_action_e;

  typedef struct packed {
    dph_action_e kind;
    logic [1:0] level;
    logic stream;
    logic retain;
  } dph_action_s;

endpackage : dph_pkg

// ### rtl/dph_decode.sv
// Decoder of the 32-bit prefetch instruction: match, hint action, effective address.
// Purely combinational; fed from pipeline logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "dph_params.svh"

module dph_decode #(
  parameter logic [4:0] PREALLOC_HINT = `DPH_HINT_PREALLOC_DEFAULT,
  parameter bit ENABLE_PREALLOC = 1'b0
) (
  input wire logic [31:0] i_instr,
  input wire logic [31:0] i_base_value,
  output logic o_is_prefetch,
  output dph_pkg::dph_action_s o_action,
  output logic [31:0] o_eff_addr
);
  import dph_pkg::*;

  function automatic dph_action_s hint_action(input logic [4:0] hint);
    dph_action_s a;
    a = '{kind: DPH_ACT_NOP, level: `DPH_LEVEL_L1, stream: 1'b0, retain: 1'b0};
    if (hint < `DPH_HINT_LEVELED_LIMIT) begin
      a.level = hint[4:3]; // [RQ17]
      case (hint[2:0])
        `DPH_HINT_LOAD: a.kind = DPH_ACT_LOAD; // [RQ14]
        `DPH_HINT_STORE: a.kind = DPH_ACT_STORE; // [RQ15]
        `DPH_HINT_LRU: a.kind = DPH_ACT_LRU;
        `DPH_HINT_LOAD_STREAMED: begin
          a.kind = DPH_ACT_LOAD; // [RQ16]
          a.stream = 1'b1;
        end
        `DPH_HINT_STORE_STREAMED: begin
          a.kind = DPH_ACT_STORE; // [RQ16]
          a.stream = 1'b1;
        end
        `DPH_HINT_LOAD_RETAINED: begin
          a.kind = DPH_ACT_LOAD; // [RQ16]
          a.retain = 1'b1;
        end
        `DPH_HINT_STORE_RETAINED: begin
          a.kind = DPH_ACT_STORE; // [RQ16]
          a.retain = 1'b1;
        end
        default: a.kind = DPH_ACT_NOP; // [RQ19]
      endcase
    end else if (hint == `DPH_HINT_RESERVED) begin
      a.kind = DPH_ACT_RESERVED; // [RQ18]
    end else if (ENABLE_PREALLOC && hint == PREALLOC_HINT) begin
      a.kind = DPH_ACT_PREALLOC; // [RQ5]
    end
    return a; // [RQ3]
  endfunction : hint_action

  always_comb begin
    o_is_prefetch = (i_instr[`DPH_MAJOR_MSB:`DPH_MAJOR_LSB] == `DPH_MAJOR_OPCODE)
      && (i_instr[`DPH_MINOR_MSB:`DPH_MINOR_LSB] == `DPH_MINOR_CODE)
      && (i_instr[`DPH_ZERO_MSB:`DPH_ZERO_LSB] == `DPH_ZERO_FIELD); // [RQ1]
    o_action = hint_action(i_instr[`DPH_HINT_MSB:`DPH_HINT_LSB]);
    o_eff_addr = i_base_value + {{(32 - `DPH_OFFSET_WIDTH){i_instr[`DPH_OFFSET_MSB]}},
      i_instr[`DPH_OFFSET_MSB:`DPH_OFFSET_LSB]}; // [RQ2]
  end

endmodule : dph_decode
`default_nettype wire

// ### bench/dph_monitor.sv
// Port checker for the data prefetch handler.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module dph_monitor #(
  parameter int LINE_BYTES = 32
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_instr_valid,
  input wire logic [31:0] i_instr,
  input wire logic [31:0] i_base_value,
  input wire logic o_ready,
  input wire logic o_busy,
  input wire logic o_retire,
  input wire logic o_ri_exc,
  input wire logic o_xlat_req,
  input wire logic [31:0] o_xlat_vaddr,
  input wire logic i_xlat_ack,
  input wire logic i_xlat_fault,
  input wire logic i_xlat_uncached,
  input wire logic i_sync_pending,
  input wire logic o_mem_req,
  input wire logic [31:0] o_mem_addr,
  input wire logic i_mem_ready,
  input wire logic i_mem_done
);
  logic take;
  assign take = o_ready && i_instr_valid && i_instr[31:26] == 6'h18 && i_instr[15:12] == 4'h2
    && i_instr[11:9] == 3'h0;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  AST_ADDR: assert property ($rose(o_xlat_req) |-> o_xlat_vaddr == $past(i_base_value)
    + {{23{$past(i_instr[8])}}, $past(i_instr[8:0])}) else $error("wrong effective address");
  AST_RSVD: assert property (take && i_instr[25:21] == 5'h18 |=> o_ri_exc && o_retire)
    else $error("hint 24 without exception");
  AST_NOP: assert property (take && i_instr[25:21] == 5'h03 |=> o_retire && !o_ri_exc && o_ready)
    else $error("idle hint not retired at once");
  AST_DROP: assert property (o_xlat_req && i_xlat_ack && (i_xlat_fault || i_xlat_uncached)
    |=> (o_retire && !o_mem_req) ##1 !o_mem_req) else $error("dropped prefetch went to memory");
  AST_ORDER: assert property ($rose(o_mem_req) |-> !$past(i_sync_pending))
    else $error("request raised over pending barrier work");
  AST_HOLD: assert property (o_mem_req && !i_mem_ready |=> o_mem_req && $stable(o_mem_addr))
    else $error("memory request not held");
  AST_LINE: assert property (o_mem_req |-> o_mem_addr % LINE_BYTES == 0)
    else $error("memory address not block aligned");
  AST_DONE: assert property (o_busy && !o_mem_req && !o_xlat_req && i_mem_done
    |=> o_retire && o_ready) else $error("no retire after completion");
  AST_IGNORE: assert property (o_ready && i_instr_valid && i_instr[11:9] != 3'h0
    |=> o_ready && !o_retire && !o_xlat_req) else $error("malformed word was taken");
endmodule : dph_monitor
bind dph_prefetch_handler dph_monitor #(.LINE_BYTES(LINE_BYTES)) u_mon (.i_ref_clk(i_ref_clk),
  .i_sys_rst(i_sys_rst), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
  .i_base_value(i_base_value), .o_ready(o_ready), .o_busy(o_busy), .o_retire(o_retire),
  .o_ri_exc(o_ri_exc), .o_xlat_req(o_xlat_req), .o_xlat_vaddr(o_xlat_vaddr),
  .i_xlat_ack(i_xlat_ack), .i_xlat_fault(i_xlat_fault), .i_xlat_uncached(i_xlat_uncached),
  .i_sync_pending(i_sync_pending), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr),
  .i_mem_ready(i_mem_ready), .i_mem_done(i_mem_done));
`default_nettype wire

// ### bench/dph_cache_model.sv
// Behavioural translation and cache side facing the prefetch handler.
// Assumes the handler holds each request until it is answered.
`timescale 1ns/1ps
`default_nettype none
module dph_cache_model (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_xlat_req,
  input wire logic [31:0] i_xlat_vaddr,
  input wire logic i_mem_req,
  input wire logic i_fault,
  input wire logic i_uncached,
  input wire logic i_coherent,
  input wire logic i_slow,
  output logic o_ack,
  output logic o_fault,
  output logic o_uncached,
  output logic o_coherent,
  output logic [2:0] o_cache_attr,
  output logic [31:0] o_paddr,
  output logic o_mem_ready,
  output logic o_mem_done,
  output logic o_mem_err
);
  logic [2:0] cnt;
  logic busy;
  // Outside the answer cycle the result lines carry inverted values, never a stale copy
  assign o_fault = o_ack ~^ i_fault;
  assign o_uncached = o_ack ~^ i_uncached;
  assign o_coherent = o_ack ~^ i_coherent;
  assign o_cache_attr = {3{~o_ack}} ^ (i_coherent ? 3'h5 : 3'h3);
  assign o_paddr = o_ack ? i_xlat_vaddr + 32'h2000_0000 : ~i_xlat_vaddr;
  // Slow transfers complete with an error so the error path is exercised
  assign o_mem_err = o_mem_done ? i_slow : 1'b1;
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      {o_ack, o_mem_ready, o_mem_done, busy} <= 4'h0;
      cnt <= 3'h0;
    end else begin
      {o_ack, o_mem_ready, o_mem_done} <= 3'h0;
      if ((i_xlat_req && !o_ack) || (i_mem_req && !o_mem_ready) || busy) begin
        cnt <= cnt + 3'h1;
        if (cnt == (i_slow ? 3'h4 : 3'h0)) begin
          cnt <= 3'h0;
          if (i_xlat_req && !o_ack) o_ack <= 1'b1;
          else if (busy) o_mem_done <= 1'b1;
          else o_mem_ready <= 1'b1;
          busy <= i_mem_req && !busy && !i_xlat_req;
        end
      end
    end
  end
endmodule : dph_cache_model
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the prefetch handler with a behavioural cache side.
// Assumes the design files and the checker are compiled ahead of it.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dph_pkg::*;
  logic i_ref_clk, i_sys_rst, i_instr_valid, i_sync_pending, fault, unc, coh, slow, ri, be;
  logic [31:0] i_instr, i_base_value, o_xlat_vaddr, o_mem_addr, i_xlat_paddr, va;
  logic o_ready, o_busy, o_retire, o_ri_exc, o_bus_err_exc, o_xlat_req, o_mem_req;
  logic o_mem_stream, o_mem_retain, o_mem_coherent, i_xlat_ack, i_xlat_fault;
  logic i_xlat_uncached, i_xlat_coherent, i_mem_ready, i_mem_done, i_mem_err;
  logic [2:0] o_mem_cache_attr, i_xlat_cache_attr;
  logic [1:0] o_mem_level;
  logic [42:0] cap;
  dph_action_e o_mem_kind;
  int fail_count, comparisons, nmem, first_mem, cyc;
  dph_prefetch_handler DUT (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_base_value(i_base_value),
    .o_ready(o_ready), .o_busy(o_busy), .o_retire(o_retire), .o_ri_exc(o_ri_exc),
    .o_bus_err_exc(o_bus_err_exc), .o_xlat_req(o_xlat_req), .o_xlat_vaddr(o_xlat_vaddr),
    .i_xlat_ack(i_xlat_ack), .i_xlat_fault(i_xlat_fault), .i_xlat_uncached(i_xlat_uncached),
    .i_xlat_coherent(i_xlat_coherent), .i_xlat_cache_attr(i_xlat_cache_attr),
    .i_xlat_paddr(i_xlat_paddr), .i_sync_pending(i_sync_pending), .o_mem_req(o_mem_req),
    .o_mem_addr(o_mem_addr), .o_mem_kind(o_mem_kind), .o_mem_level(o_mem_level),
    .o_mem_stream(o_mem_stream), .o_mem_retain(o_mem_retain),
    .o_mem_coherent(o_mem_coherent), .o_mem_cache_attr(o_mem_cache_attr),
    .i_mem_ready(i_mem_ready), .i_mem_done(i_mem_done), .i_mem_err(i_mem_err));
  dph_cache_model u_far (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_xlat_req(o_xlat_req),
    .i_xlat_vaddr(o_xlat_vaddr), .i_mem_req(o_mem_req), .i_fault(fault), .i_uncached(unc),
    .i_coherent(coh), .i_slow(slow), .o_ack(i_xlat_ack), .o_fault(i_xlat_fault),
    .o_uncached(i_xlat_uncached), .o_coherent(i_xlat_coherent),
    .o_cache_attr(i_xlat_cache_attr),
    .o_paddr(i_xlat_paddr), .o_mem_ready(i_mem_ready), .o_mem_done(i_mem_done),
    .o_mem_err(i_mem_err));
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  // Offers one prefetch and watches it to retirement; barrier work is lifted after six cycles
  task automatic run(input logic [4:0] hint, input logic [8:0] off);
    @(posedge i_ref_clk);
    i_instr_valid <= 1'b1;
    i_instr <= {6'h18, hint, 5'h07, 4'h2, 3'h0, off};
    i_base_value <= 32'h1000_0100;
    @(posedge i_ref_clk);
    i_instr_valid <= 1'b0;
    {nmem, first_mem, cap, va} = {32'h0, -32'sd1, 43'h0, 32'h0};
    for (cyc = 0; cyc < 40; cyc++) begin
      if (cyc == 6) i_sync_pending <= 1'b0;
      #1;
      if (o_xlat_req === 1'b1) va = o_xlat_vaddr;
      if (o_mem_req === 1'b1) begin
        nmem++;
        if (first_mem < 0) first_mem = cyc;
        cap = {o_mem_kind, o_mem_level, o_mem_stream, o_mem_retain, o_mem_coherent,
          o_mem_cache_attr, o_mem_addr};
      end
      if (o_retire === 1'b1) break;
      @(posedge i_ref_clk);
    end
    ri = o_ri_exc;
    be = o_bus_err_exc;
    if (cyc == 40) begin
      chk(cyc, 39);
      print_verdict();
    end
  endtask : run
  task automatic sc_hints;
    logic [2:0] k;
    logic [31:0] ev;
    for (int h = 0; h < 24; h++) begin
      slow = h[1];
      run(5'(h), h[0] ? 9'h1f0 : 9'h0ff);
      ev = 32'h1000_0100 + (h[0] ? 32'hffff_fff0 : 32'h0000_00ff);
      k = (h[2:0] == 3'h2) ? DPH_ACT_LRU : (h[0] ? DPH_ACT_STORE : DPH_ACT_LOAD);
      if (h[2:0] == 3'h3) begin
        chk({nmem, cyc}, 64'h0);
      end else begin
        chk(va, ev);
        chk(be, 1'b0);
        chk(cap, {k, 2'(h >> 3), h[2:1] == 2'b10, h[2:1] == 2'b11, 4'h3, ev + 32'h2000_0000 & ~32'h1f});
      end
    end
  endtask : sc_hints
  task automatic sc_reserved;
    for (int h = 24; h < 32; h++) begin
      run(5'(h), 9'h000);
      chk({nmem, 31'h0, ri}, {32'h0, 31'h0, h == 24});
    end
  endtask : sc_reserved
  task automatic sc_drop;
    fault = 1'b1;
    run(5'h00, 9'h004);
    chk({nmem, 31'h0, ri}, 64'h0);
    {fault, unc} = 2'b01;
    run(5'h01, 9'h1fc);
    chk({nmem, 31'h0, ri}, 64'h0);
    unc = 1'b0;
  endtask : sc_drop
  task automatic sc_order;
    coh = 1'b1;
    @(posedge i_ref_clk);
    i_sync_pending <= 1'b1;
    run(5'h06, 9'h010);
    chk(cap[35:32], 4'hd);
    chk(first_mem >= 7, 1);
    coh = 1'b0;
  endtask : sc_order
  task automatic sc_ignore;
    for (int i = 0; i < 2; i++) begin
      @(posedge i_ref_clk);
      i_instr_valid <= 1'b1;
      i_instr <= i ? 32'h6400_2000 : 32'h6000_2a00;
      @(posedge i_ref_clk);
      i_instr_valid <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      #1;
      chk({o_ready, o_retire, o_xlat_req, o_mem_req}, 4'h8);
    end
  endtask : sc_ignore
  initial begin
    {i_sys_rst, i_instr_valid, i_sync_pending, fault, unc, coh, slow} = 7'h40;
    {i_instr, i_base_value, fail_count, comparisons} = '0;
    repeat (5) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    chk({o_ready, o_busy, o_retire, o_xlat_req, o_mem_req}, 5'h10);
    sc_hints();
    sc_reserved();
    sc_drop();
    sc_order();
    sc_ignore();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
